// [rtl/phy_regs_params.svh]
/*
 Register offsets, field positions, reset values for the PHY management bank.
 Assumes APB byte addressing, one 32-bit word per register.
*/
`ifndef PHY_REGS_PARAMS_SVH
`define PHY_REGS_PARAMS_SVH
// Register indices and byte addresses
`define IDX_PARTNER 8'h05
`define IDX_EXPAN 8'h06
`define IDX_STATE 8'h10
`define IDX_SPECIAL 8'h11
`define IDX_RSVD 8'h12
`define ADDR_OF(idx) ({2'h0, idx, 2'h0})
// Expansion register fields
`define EXP_PDF_BIT 4
`define EXP_LPNP_BIT 3
`define EXP_LNP_BIT 2
`define EXP_PR_BIT 1
`define EXP_LPAN_BIT 0
// Status and control fields
`define SC_RPD_BIT 13
`define SC_SYNC_BIT 11
`define SC_PD100_BIT 10
`define SC_PD10_BIT 9
`define SC_POL_BIT 8
`define SC_ADDR_LSB 2
`define SC_SPEED_BIT 1
`define SC_DUPLEX_BIT 0
// Reset values
`define SC_RPD_RST 1'b1
`define PD_RST 1'b1
`define SPECIAL_RST 16'h0000
`define LOCAL_NP_ABLE 1'b0
`endif

// [rtl/phy_regs_pkg.sv]
/*
 Types for the PHY management register bank.
 Assumes the params header supplies all numbers.
*/
package phy_regs_pkg;
    // Partner ability word as received
    typedef struct packed {
        logic next_page;
        logic ack;
        logic remote_fault;
        logic [7:0] tech;
        logic [4:0] selector;
    } partner_word_t;
    // Special control bits, bit 15 first
    typedef struct packed {
        logic scram_bypass;
        logic enc_bypass;
        logic force_h_pat;
        logic force_34_pat;
        logic force_link_ok;
        logic sym_err_en;
        logic crs_dis;
        logic dyn_pd_dis;
        logic an_loopback;
        logic tx_hiz;
        logic force_pol_rev;
        logic auto_pol_dis;
        logic squelch_dis;
        logic ext_squelch;
        logic link_int_dis;
        logic jabber_dis;
    } special_ctl_t;
    // Line status seen by the bank
    typedef struct packed {
        logic rx_sync;
        logic pd100;
        logic pd10;
        logic pol_rev;
        logic speed100;
        logic full_duplex;
    } line_status_t;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ACCESS
    } apb_state_t;
endpackage

// [rtl/phy_flag_latch.sv]
/*
 Sticky high flag cleared by a read strobe.
 Assumes set and read strobes synchronous to the clock; set wins.
*/
`timescale 1ns/10ps
module phy_flag_latch (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // Events
    input wire logic set_i,
    input wire logic rd_clr_i,
    // Flag
    output logic flag_o
);
    logic flag_q;
    logic flag_d;
    always_comb begin
        flag_d = flag_q;
        if (rd_clr_i) begin
            flag_d = 1'b0;
        end
        if (set_i) begin
            flag_d = 1'b1;
        end
    end
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end
    assign flag_o = flag_q;
endmodule

// [rtl/phy_autoneg_regs.sv]
/*
 PHY management register bank: partner ability, expansion, status and
 control, special control and a reserved slot, behind an APB slave.
 Assumes line status inputs synchronous to core_clk_i.
*/
// Function
// - Partner next page, remote fault readable
// - Acknowledge bit shows partner word received
// - Partner tech and selector fields readable
// - Parallel fault latched, cleared by read
// - Page received latched, cleared by read
// - Partner next page and autoneg able
// - Local next page able reads zero
// - Reduced power disable resets to one
// - Deserializer sync status readable
// - Power-down bits reset to one
// - Ten megabit polarity shown
// - Sampled PHY address readable
// - Resolved speed and duplex shown
// - Scrambler and encoder bypass controls
// - H and 34 test pattern forcing
// - Force hundred megabit link valid
// - Symbol error output enable
// - Carrier sense disable control
// - Dynamic power-down inhibit control
// - Autoneg loopback and transmit tri-state
// - Auto polarity disable, forced polarity
// - Squelch, link integrity, jabber controls
`timescale 1ns/10ps
`include "phy_regs_params.svh"
module phy_autoneg_regs
    import phy_regs_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Auto-negotiation receive side
    input wire logic partner_valid_i,
    input wire partner_word_t partner_word_i,
    input wire logic page_rx_i,
    input wire logic par_fault_i,
    input wire logic partner_np_able_i,
    input wire logic partner_an_able_i,
    // Line status
    input wire line_status_t line_status_i,
    input wire logic [4:0] phy_addr_i,
    input wire logic addr_sample_i,
    // Controls to the PHY
    output special_ctl_t special_ctl_o,
    output logic auto_rpd_en_o
);

    ////////////////////////////////////////////////////////////////////////
    // Storage
    partner_word_t partner_q;
    logic ack_q;
    logic rpd_dis_q;
    logic [4:0] addr_q;
    logic pd100_q;
    logic pd10_q;
    special_ctl_t special_q;
    logic pdf_flag;
    logic pr_flag;
    logic [31:0] prdata_q;
    apb_state_t state_q;

    function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
        hit = (a == `ADDR_OF(idx));
    endfunction

    logic setup;
    logic rd_take;
    logic wr_take;
    logic mapped;
    logic rd_exp;
    logic [15:0] exp_word;
    logic [15:0] state_word;
    logic [15:0] rd_word;

    assign setup = psel_i && !penable_i;
    assign wr_take = psel_i && penable_i && pwrite_i && !pslverr_o;
    assign rd_take = setup && !pwrite_i;
    assign mapped = hit(paddr_i, `IDX_PARTNER) || hit(paddr_i, `IDX_EXPAN) ||
                    hit(paddr_i, `IDX_STATE) || hit(paddr_i, `IDX_SPECIAL) ||
                    hit(paddr_i, `IDX_RSVD);
    // clear after read data is latched
    assign rd_exp = psel_i && penable_i && !pwrite_i && hit(paddr_i, `IDX_EXPAN);

    ////////////////////////////////////////////////////////////////////////
    // APB access phase: one wait-free cycle, pready in access
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (setup) begin
                        state_q <= ST_ACCESS;
                    end
                end
                ST_ACCESS: begin
                    state_q <= setup ? ST_ACCESS : ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end
    assign pready_o = psel_i && penable_i;
    assign pslverr_o = psel_i && penable_i && !mapped;

    ////////////////////////////////////////////////////////////////////////
    // Partner ability capture
    // partner bits captured
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            partner_q <= '0;
        end else if (partner_valid_i) begin
            partner_q <= partner_word_i;
        end
    end
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            ack_q <= 1'b0;
        end else if (partner_valid_i) begin
            ack_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky expansion flags
    // parallel fault latch
    phy_flag_latch u_pdf (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .set_i(par_fault_i),
        .rd_clr_i(rd_exp),
        .flag_o(pdf_flag)
    );
    phy_flag_latch u_pr (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .set_i(page_rx_i),
        .rd_clr_i(rd_exp),
        .flag_o(pr_flag)
    );

    ////////////////////////////////////////////////////////////////////////
    // Status: address sample and power-down state
    // address sampled on strobe
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            addr_q <= 5'h00;
        end else if (addr_sample_i) begin
            addr_q <= phy_addr_i;
        end
    end
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            pd100_q <= `PD_RST;
            pd10_q <= `PD_RST;
        end else begin
            pd100_q <= line_status_i.pd100;
            pd10_q <= line_status_i.pd10;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Writable registers
    // reduced power disable
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            rpd_dis_q <= `SC_RPD_RST;
        end else if (wr_take && hit(paddr_i, `IDX_STATE) && pstrb_i[1]) begin
            rpd_dis_q <= pwdata_i[`SC_RPD_BIT];
        end
    end
    assign auto_rpd_en_o = !rpd_dis_q;
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            special_q <= `SPECIAL_RST;
        end else if (wr_take && hit(paddr_i, `IDX_SPECIAL)) begin
            if (pstrb_i[0]) begin
                special_q[7:0] <= pwdata_i[7:0];
            end
            if (pstrb_i[1]) begin
                special_q[15:8] <= pwdata_i[15:8];
            end
        end
    end
    assign special_ctl_o = special_q;

    ////////////////////////////////////////////////////////////////////////
    // Read path
    always_comb begin
        exp_word = 16'h0000;
        exp_word[`EXP_LPNP_BIT] = partner_np_able_i;
        exp_word[`EXP_LPAN_BIT] = partner_an_able_i;
        exp_word[`EXP_LNP_BIT] = `LOCAL_NP_ABLE;
        // event in setup cycle shows in data
        exp_word[`EXP_PDF_BIT] = pdf_flag || par_fault_i;
        exp_word[`EXP_PR_BIT] = pr_flag || page_rx_i;
    end
    always_comb begin
        state_word = 16'h0000;
        state_word[`SC_RPD_BIT] = rpd_dis_q;
        state_word[`SC_SYNC_BIT] = line_status_i.rx_sync;
        state_word[`SC_PD100_BIT] = pd100_q;
        state_word[`SC_PD10_BIT] = pd10_q;
        state_word[`SC_POL_BIT] = line_status_i.pol_rev;
        state_word[`SC_ADDR_LSB +: 5] = addr_q;
        state_word[`SC_SPEED_BIT] = line_status_i.speed100;
        state_word[`SC_DUPLEX_BIT] = line_status_i.full_duplex;
    end
    always_comb begin
        rd_word = 16'h0000;
        if (hit(paddr_i, `IDX_PARTNER)) begin
            rd_word = {partner_q.next_page, ack_q, partner_q[13:0]};
        end else if (hit(paddr_i, `IDX_EXPAN)) begin
            rd_word = exp_word;
        end else if (hit(paddr_i, `IDX_STATE)) begin
            rd_word = state_word;
        end else if (hit(paddr_i, `IDX_SPECIAL)) begin
            rd_word = special_q;
        end
    end
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            prdata_q <= 32'h0000_0000;
        end else if (rd_take) begin
            prdata_q <= {16'h0000, rd_word};
        end
    end
    assign prdata_o = prdata_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    AST_PDF_HOLD: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        par_fault_i |=> pdf_flag) else $error("parallel fault not latched");
    AST_PR_CLEAR: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        rd_exp && !page_rx_i |=> !pr_flag) else $error("page flag not cleared");
    AST_RD_FIRST: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        rd_take && hit(paddr_i, `IDX_EXPAN) && pr_flag |=> prdata_o[`EXP_PR_BIT])
        else $error("read lost page flag");
    AST_SET_WINS: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        rd_exp && par_fault_i |=> pdf_flag) else $error("event lost on read");
    AST_ACK: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        partner_valid_i |=> ack_q ##1 ack_q) else $error("ack not held");
    AST_RSVD: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        rd_take && hit(paddr_i, `IDX_RSVD) |=> prdata_o == 32'h0) else $error("reserved nonzero");
    AST_LNP: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        rd_take && hit(paddr_i, `IDX_EXPAN) |=> !prdata_o[`EXP_LNP_BIT])
        else $error("local next page set");
    AST_SPEC_WR: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        wr_take && hit(paddr_i, `IDX_SPECIAL) && pstrb_i[1:0] == 2'h3 |=>
        special_ctl_o == $past(pwdata_i[15:0])) else $error("special write lost");
    AST_RPD: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        wr_take && hit(paddr_i, `IDX_STATE) && pstrb_i[1] |=>
        auto_rpd_en_o == !$past(pwdata_i[13])) else $error("reduced power ctl wrong");
    AST_ADDR: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        addr_sample_i |=> addr_q == $past(phy_addr_i)) else $error("address not sampled");
    AST_CLR_ACC: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        rd_exp |-> state_q == ST_ACCESS)
        else $error("flag clear outside access");
    AST_PDF_RD: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        rd_take && hit(paddr_i, `IDX_EXPAN) && (pdf_flag || par_fault_i) |=>
        prdata_o[`EXP_PDF_BIT]) else $error("parallel fault lost from read data");
    AST_PDF_CLEAR: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        rd_exp && !par_fault_i |=> !pdf_flag) else $error("fault flag not cleared");
    AST_PR_HOLD: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        page_rx_i |=> pr_flag) else $error("page flag not latched");
    AST_PARTNER: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        partner_valid_i |=> partner_q.next_page == $past(partner_word_i.next_page) &&
        partner_q.remote_fault == $past(partner_word_i.remote_fault))
        else $error("partner bits not captured");
    AST_PART_RD: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        rd_take && hit(paddr_i, `IDX_PARTNER) |=>
        prdata_o[12:5] == $past(partner_q.tech) && prdata_o[4:0] == $past(partner_q.selector))
        else $error("partner fields wrong");
    AST_ACK_RD: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        rd_take && hit(paddr_i, `IDX_PARTNER) |=> prdata_o[14] == $past(ack_q))
        else $error("acknowledge not read back");
    AST_ACK_STAY: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        ack_q |=> ack_q) else $error("acknowledge dropped");
    AST_NP_AN: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        rd_take && hit(paddr_i, `IDX_EXPAN) |=>
        prdata_o[`EXP_LPNP_BIT] == $past(partner_np_able_i) &&
        prdata_o[`EXP_LPAN_BIT] == $past(partner_an_able_i)) else $error("partner ability wrong");
    AST_SYNC: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        rd_take && hit(paddr_i, `IDX_STATE) |=>
        prdata_o[`SC_SYNC_BIT] == $past(line_status_i.rx_sync)) else $error("sync bit wrong");
    AST_RST_VALS: assert property (@(posedge core_clk_i)
        !rst_n_i |=> pd100_q && pd10_q && rpd_dis_q && special_q == `SPECIAL_RST)
        else $error("reset values wrong");
    AST_POL: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        rd_take && hit(paddr_i, `IDX_STATE) |=>
        prdata_o[`SC_POL_BIT] == $past(line_status_i.pol_rev)) else $error("polarity bit wrong");
    AST_ADDR_RD: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        rd_take && hit(paddr_i, `IDX_STATE) |=>
        prdata_o[`SC_ADDR_LSB +: 5] == $past(addr_q)) else $error("address not read back");
    AST_SPD_DPX: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        rd_take && hit(paddr_i, `IDX_STATE) |=>
        prdata_o[`SC_SPEED_BIT] == $past(line_status_i.speed100) &&
        prdata_o[`SC_DUPLEX_BIT] == $past(line_status_i.full_duplex))
        else $error("speed or duplex wrong");
    AST_RSVD_BITS: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        rd_take && hit(paddr_i, `IDX_STATE) |=>
        prdata_o[31:14] == 18'h00000 && !prdata_o[12] && !prdata_o[7])
        else $error("reserved status bits set");
    AST_SPEC_HOLD: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        !(wr_take && hit(paddr_i, `IDX_SPECIAL)) |=> $stable(special_ctl_o))
        else $error("controls changed without write");
    AST_SPEC_RD: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        rd_take && hit(paddr_i, `IDX_SPECIAL) |=> prdata_o[15:0] == $past(special_ctl_o))
        else $error("control read back wrong");
    AST_ERR_NOWR: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        pslverr_o |=> $stable(special_ctl_o) && $stable(auto_rpd_en_o))
        else $error("unmapped write took effect");
    AST_RPD_HOLD: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        !(wr_take && hit(paddr_i, `IDX_STATE) && pstrb_i[1]) |=> $stable(auto_rpd_en_o))
        else $error("power control changed without write");
    AST_RD_STAND: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        !rd_take |=> $stable(prdata_o)) else $error("read data changed outside setup");
    COV_EXP_READ: cover property (@(posedge core_clk_i) rd_exp && pr_flag);
    COV_SPEC_WR: cover property (@(posedge core_clk_i) wr_take && hit(paddr_i, `IDX_SPECIAL));
    COV_COLLIDE: cover property (@(posedge core_clk_i) rd_exp && par_fault_i);
    COV_UNMAPPED: cover property (@(posedge core_clk_i) pslverr_o);
    COV_PARTNER: cover property (@(posedge core_clk_i) partner_valid_i);
endmodule

// [testbench/apb_mgmt_master.sv]
/*
 APB management master standing in for the station controller.
 Assumes callers enter its task just after a rising clock edge.
*/
`timescale 1ns/10ps
module apb_mgmt_master (
    // Clock
    input wire logic core_clk_i,
    // APB request
    output logic psel_o,
    output logic penable_o,
    output logic pwrite_o,
    output logic [11:0] paddr_o,
    output logic [31:0] pwdata_o,
    output logic [3:0] pstrb_o,
    // APB answer
    input wire logic [31:0] prdata_i,
    input wire logic pready_i,
    input wire logic pslverr_i
);
    initial begin
        psel_o = 1'b0;
        penable_o = 1'b0;
        pwrite_o = 1'b0;
        paddr_o = 12'h000;
        pwdata_o = 32'h0;
        pstrb_o = 4'h0;
    end
    ////////////////////////////////////////////////////////////////////////
    // One transfer: setup, access held until pready, then release
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        psel_o <= 1'b1;
        penable_o <= 1'b0;
        pwrite_o <= w;
        paddr_o <= a;
        pwdata_o <= d;
        pstrb_o <= 4'h3;
        @(posedge core_clk_i);
        penable_o <= 1'b1;
        do @(posedge core_clk_i); while (pready_i !== 1'b1);
        r = prdata_i;
        e = pslverr_i;
        psel_o <= 1'b0;
        penable_o <= 1'b0;
    endtask
endmodule

// [testbench/tb.sv]
/*
 Self-checking bench for the PHY management register bank.
 Assumes no wait states are promised; waits are bounded by a cycle ceiling.
*/
`timescale 1ns/10ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin mismatches++; \
    $display("Error at %0t: got %h expected %h", $time, a, b); end end
module tb;
    import phy_regs_pkg::*;
    logic core_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rv;
    logic [3:0] pstrb;
    logic partner_valid = 1'b0, page_rx = 1'b0, par_fault = 1'b0;
    logic np_able = 1'b0, an_able = 1'b0, addr_sample = 1'b0;
    logic [15:0] pword = 16'h0;
    logic [5:0] lstat = 6'b011000;
    logic [4:0] phy_addr = 5'h00;
    special_ctl_t special_ctl;
    logic auto_rpd_en, err;
    int mismatches = 0;
    int n_checks = 0;
    int cycles = 0;
    initial forever #50 core_clk_i = ~core_clk_i;
    apb_mgmt_master apb_mgmt_master_inst (.core_clk_i(core_clk_i), .psel_o(psel),
        .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata),
        .pstrb_o(pstrb), .prdata_i(prdata), .pready_i(pready), .pslverr_i(pslverr));
    phy_autoneg_regs phy_autoneg_regs_inst (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .partner_valid_i(partner_valid), .partner_word_i(pword),
        .page_rx_i(page_rx), .par_fault_i(par_fault), .partner_np_able_i(np_able),
        .partner_an_able_i(an_able), .line_status_i(lstat), .phy_addr_i(phy_addr),
        .addr_sample_i(addr_sample), .special_ctl_o(special_ctl),
        .auto_rpd_en_o(auto_rpd_en));
    ////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            print_verdict();
        end
    end
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic e_exp);
        apb_mgmt_master_inst.xfer(1'b1, a, d, rv, err);
        `CHK(err, e_exp)
        @(posedge core_clk_i);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic e_exp);
        apb_mgmt_master_inst.xfer(1'b0, a, 32'h0, rv, err);
        `CHK(err, e_exp)
        `CHK(rv, exp)
        @(posedge core_clk_i);
    endtask
    task automatic pulse(input int which);
        if (which == 0) begin
            partner_valid <= 1'b1;
        end else if (which == 1) begin
            page_rx <= 1'b1;
        end else begin
            addr_sample <= 1'b1;
        end
        @(posedge core_clk_i);
        partner_valid <= 1'b0;
        page_rx <= 1'b0;
        addr_sample <= 1'b0;
        @(posedge core_clk_i);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        @(posedge core_clk_i);
        rd(12'h040, 32'h0000_2600, 1'b0);
        rd(12'h014, 32'h0, 1'b0);
        rd(12'h044, 32'h0, 1'b0);
        `CHK(special_ctl, 16'h0000)
        `CHK(auto_rpd_en, 1'b0)
        // partner word capture, input ack ignored
        pword <= {1'b1, 1'b0, 1'b1, 8'ha5, 5'h01};
        pulse(0);
        rd(12'h014, 32'h0000_f4a1, 1'b0);
        wr(12'h014, 32'hffff_ffff, 1'b0);
        rd(12'h014, 32'h0000_f4a1, 1'b0);
        np_able <= 1'b1;
        an_able <= 1'b1;
        par_fault <= 1'b1;
        pulse(1);
        par_fault <= 1'b0;
        rd(12'h018, 32'h0000_001b, 1'b0);
        page_rx <= 1'b1;
        rd(12'h018, 32'h0000_000b, 1'b0);
        page_rx <= 1'b0;
        rd(12'h018, 32'h0000_000b, 1'b0);
        rd(12'h018, 32'h0000_0009, 1'b0);
        wr(12'h040, 32'hffff_dfff, 1'b0);
        `CHK(auto_rpd_en, 1'b1)
        lstat <= 6'b100111;
        phy_addr <= 5'h15;
        pulse(2);
        rd(12'h040, 32'h0000_0957, 1'b0);
        wr(12'h040, 32'h0000_2000, 1'b0);
        `CHK(auto_rpd_en, 1'b0)
        for (int i = 0; i < 16; i++) begin
            wr(12'h044, 32'h1 << i, 1'b0);
            `CHK(special_ctl, 16'h1 << i)
            rd(12'h044, 32'h1 << i, 1'b0);
        end
        wr(12'h044, 32'hffff_ffff, 1'b0);
        rd(12'h044, 32'h0000_ffff, 1'b0);
        wr(12'h048, 32'hffff_ffff, 1'b0);
        rd(12'h048, 32'h0, 1'b0);
        wr(12'h00c, 32'hffff_ffff, 1'b1);
        rd(12'h00c, 32'h0, 1'b1);
        print_verdict();
    end
endmodule
